// ===== ebs_pkg.sv
package ebs_pkg;

  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  // address lines that qualify a store access (A0..A16)
  localparam int QUAL_ADDR_W = 17;

  // strobe low time in clock cycles at 20 MHz
  localparam int STROBE_NS     = 100;
  localparam int CLK_PERIOD_NS = 50;
  localparam int STROBE_CYCLES = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // port d bit positions shared with the select pins
  localparam int PUR_PROGRAM_SEL_BIT = 8;
  localparam int PUR_DATA_SEL_BIT    = 9;

  // reset values of pins
  localparam logic RST_STROBE_N = 1'b1;
  localparam logic RST_OE       = 1'b0;
  localparam logic RST_PULLUP   = 1'b1;

  // memory space of an access
  localparam logic SPACE_PROGRAM = 1'b0;
  localparam logic SPACE_DATA    = 1'b1;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SETUP  = 2'b01,
    ST_STROBE = 2'b10,
    ST_HOLD   = 2'b11
  } ebs_state_type;

  typedef struct packed {
    logic              write;
    logic              space;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } ebs_req_type;

endpackage

// ===== ebs_sram_model.sv
`timescale 1ns/1ps
module ebs_sram_model
  import ebs_pkg::*;
(
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] data_i,
  input  wire logic              data_oe_i,
  input  wire logic              store_n_i,
  input  wire logic              fetch_n_i,
  input  wire logic              select_n_i,
  output logic      [DATA_W-1:0] data_o
);
  logic [DATA_W-1:0] mem [0:255];
  logic [DATA_W-1:0] last = 16'h0;
  always @(posedge store_n_i) begin
    if (!select_n_i && data_oe_i) begin
      mem[addr_i[7:0]] = data_i;
    end
  end
  always @(negedge fetch_n_i) last = mem[addr_i[7:0]];
  // released bus shows the inverse of the last word
  assign data_o = (!fetch_n_i && !select_n_i) ? mem[addr_i[7:0]] : ~last;
endmodule

// ===== ebs_strobe_unit.sv
`timescale 1ns/1ps
// Function
// - A write drives the store strobe low with the data pins as outputs carrying write data.
// - While the store strobe is low, address lines and both selects are valid and stable.
// - With the drive-keep bit clear, address and control outputs float while the bus is idle.
// - Chip select zero resets as program select and goes low for every program access.
// - Chip select one resets as data select and goes low for every data access.
// - Setting the system pull-up disable bit turns off the store strobe pull-up.
// - The program select pin doubles as port d bit eight; pull-up enable bit 8 controls it.
// - The data select pin doubles as port d bit nine; pull-up enable bit 9 controls it.
// - A read drives the fetch strobe low with the data pins as inputs.
module ebs_strobe_unit
  import ebs_pkg::*;
#(
  parameter int STROBE_LEN = STROBE_CYCLES
) (
  input  wire logic              sys_clk_i,
  input  wire logic              reset_i,
  input  wire logic              req_valid_i,
  input  wire ebs_req_type       req_i,
  output logic                   req_ready_o,
  output logic                   done_o,
  output logic [DATA_W-1:0]      rdata_o,
  input  wire logic              bus_drive_keep_i,
  input  wire logic              system_pullup_disable_reg_i,
  input  wire logic [DATA_W-1:0] port_d_pullup_enable_reg_i,
  input  wire logic [1:0]        port_d_gpio_en_i,
  input  wire logic [1:0]        port_d_dir_i,
  input  wire logic [1:0]        port_d_out_i,
  output logic [1:0]             port_d_in_o,
  output logic [ADDR_W-1:0]      addr_o,
  output logic                   addr_oe_o,
  output logic [DATA_W-1:0]      data_o,
  output logic                   data_oe_o,
  input  wire logic [DATA_W-1:0] data_i,
  output logic                   store_strobe_n_o,
  output logic                   fetch_strobe_n_o,
  output logic                   ctrl_oe_o,
  output logic                   store_pullup_o,
  output logic                   program_select_n_o,
  output logic                   program_select_oe_o,
  input  wire logic              program_select_n_i,
  output logic                   program_select_pullup_o,
  output logic                   data_select_n_o,
  output logic                   data_select_oe_o,
  input  wire logic              data_select_n_i,
  output logic                   data_select_pullup_o
);

  localparam logic [7:0] STROBE_LAST = 8'(STROBE_LEN - 1);

  ebs_state_type state;
  ebs_state_type next_state;
  logic [7:0]    cnt;
  ebs_req_type   cur;
  ebs_req_type   sel;
  logic          start;
  logic          active;
  logic          drive;
  logic          idle_float;
  logic          idle_next;

  assign start = (state == ST_IDLE) && req_valid_i;
  // request seen by the pin logic in the cycle it is taken
  assign sel        = (state == ST_IDLE) ? req_i : cur;
  assign active     = (next_state != ST_IDLE);
  assign drive      = active || bus_drive_keep_i;
  assign idle_next  = (next_state == ST_IDLE);
  assign idle_float = idle_next && !bus_drive_keep_i;

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE:   if (req_valid_i) next_state = ST_SETUP;
      ST_SETUP:  next_state = ST_STROBE;
      ST_STROBE: if (cnt == STROBE_LAST) next_state = ST_HOLD;
      ST_HOLD:   next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      cnt <= 8'h00;
    end else if (state == ST_STROBE) begin
      cnt <= cnt + 8'h01;
    end else begin
      cnt <= 8'h00;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      cur <= '0;
    end else if (start) begin
      cur <= req_i;
    end
  end

  // handshake and read capture
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      req_ready_o <= 1'b0;
      done_o      <= 1'b0;
      rdata_o     <= '0;
    end else begin
      req_ready_o <= idle_next;
      done_o      <= (state == ST_HOLD);
      // latched as the fetch strobe rises
      if (state == ST_STROBE && cnt == STROBE_LAST && !cur.write) begin
        rdata_o <= data_i;
      end
    end
  end

  // address, data and strobes
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      addr_o           <= '0;
      addr_oe_o        <= RST_OE;
      data_o           <= '0;
      data_oe_o        <= RST_OE;
      ctrl_oe_o        <= RST_OE;
      store_strobe_n_o <= RST_STROBE_N;
      fetch_strobe_n_o <= RST_STROBE_N;
    end else begin
      if (active) begin
        addr_o <= sel.addr;
        data_o <= sel.wdata;
      end
      addr_oe_o        <= drive;
      ctrl_oe_o        <= drive;
      data_oe_o        <= active && sel.write;
      store_strobe_n_o <= !(next_state == ST_STROBE && sel.write);
      fetch_strobe_n_o <= !(next_state == ST_STROBE && !sel.write);
    end
  end

  // select pins with their port d alternate use
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      program_select_n_o  <= RST_STROBE_N;
      program_select_oe_o <= RST_OE;
      data_select_n_o     <= RST_STROBE_N;
      data_select_oe_o    <= RST_OE;
      port_d_in_o         <= 2'h0;
    end else begin
      if (port_d_gpio_en_i[0]) begin
        program_select_n_o  <= port_d_out_i[0];
        program_select_oe_o <= port_d_dir_i[0];
      end else begin
        program_select_n_o  <= !(active && sel.space == SPACE_PROGRAM);
        program_select_oe_o <= drive;
      end
      if (port_d_gpio_en_i[1]) begin
        data_select_n_o  <= port_d_out_i[1];
        data_select_oe_o <= port_d_dir_i[1];
      end else begin
        data_select_n_o  <= !(active && sel.space == SPACE_DATA);
        data_select_oe_o <= drive;
      end
      port_d_in_o <= {data_select_n_i, program_select_n_i};
    end
  end

  // pull-up controls
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      store_pullup_o          <= RST_PULLUP;
      program_select_pullup_o <= RST_PULLUP;
      data_select_pullup_o    <= RST_PULLUP;
    end else begin
      store_pullup_o          <= !system_pullup_disable_reg_i;
      program_select_pullup_o <= port_d_pullup_enable_reg_i[PUR_PROGRAM_SEL_BIT];
      data_select_pullup_o    <= port_d_pullup_enable_reg_i[PUR_DATA_SEL_BIT];
    end
  end

  a_write_data_out: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    !store_strobe_n_o |-> data_oe_o && data_o == cur.wdata)
    else $error("store strobe low without write data driven");

  a_write_edge_data: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    $rose(store_strobe_n_o) |-> data_oe_o && $stable(data_o))
    else $error("write data not held at store strobe rise");

  a_store_qualify: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    !store_strobe_n_o && $past(!store_strobe_n_o) |->
      addr_oe_o && ctrl_oe_o && $stable(addr_o[QUAL_ADDR_W-1:0]))
    else $error("address not stable while store strobe low");

  a_idle_float: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    $past(idle_float) |-> !addr_oe_o && !ctrl_oe_o)
    else $error("bus driven while idle with drive-keep clear");

  a_program_select: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    (!store_strobe_n_o || !fetch_strobe_n_o) && cur.space == SPACE_PROGRAM
      && $past(!port_d_gpio_en_i[0]) |-> !program_select_n_o)
    else $error("program select not low during program access");

  a_data_select: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    (!store_strobe_n_o || !fetch_strobe_n_o) && cur.space == SPACE_DATA
      && $past(!port_d_gpio_en_i[1]) |-> !data_select_n_o && program_select_oe_o == ctrl_oe_o)
    else $error("data select not low during data access");

  a_strobe_pullup: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    system_pullup_disable_reg_i |=> !store_pullup_o)
    else $error("store strobe pull-up still on");

  a_port_d_eight: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    port_d_gpio_en_i[0] |=> program_select_n_o == $past(port_d_out_i[0])
      && program_select_pullup_o == $past(port_d_pullup_enable_reg_i[PUR_PROGRAM_SEL_BIT]))
    else $error("port d bit eight not following gpio");

  a_port_d_nine: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    port_d_gpio_en_i[1] |=> data_select_n_o == $past(port_d_out_i[1])
      && data_select_oe_o == $past(port_d_dir_i[1]))
    else $error("port d bit nine not following gpio");

  a_read_turnaround: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    !fetch_strobe_n_o |-> !data_oe_o ##[1:8] done_o)
    else $error("read without released data bus or completion");

  a_strobe_exclusive: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    !store_strobe_n_o |-> fetch_strobe_n_o)
    else $error("store and fetch strobes low together");

  a_strobe_idle_high: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    $past(idle_next) |-> store_strobe_n_o && fetch_strobe_n_o)
    else $error("strobe low while idle");

endmodule

// ===== test_external_memory_bus_strobes.sv
`timescale 1ns/1ps
module test_external_memory_bus_strobes;
  import ebs_pkg::*;
  localparam int SL = STROBE_CYCLES;
  ebs_req_type       req;
  logic [DATA_W-1:0] pur, rdata, dout, din, p_rd, d_rd;
  logic [ADDR_W-1:0] addr;
  logic [1:0]        gen, dir, pout, pin;
  logic              clk, rst, vld, keep, spud, ext, rdy, done, aoe, doe, st_n, fe_n, coe;
  logic              st_pu, ps_n, ps_oe, ps_pu, ds_n, ds_oe, ds_pu;
  logic [DATA_W-1:0] exp_p [0:255];
  logic [DATA_W-1:0] exp_d [0:255];
  int                n_errors = 0;
  int                cmp_count = 0;
  wire               ps_pin = ps_oe ? ps_n : (ps_pu | ext);
  wire               ds_pin = ds_oe ? ds_n : (ds_pu | ext);
  assign din = ps_n ? d_rd : p_rd;
  ebs_strobe_unit #(.STROBE_LEN(SL)) u_dut (
    .sys_clk_i(clk), .reset_i(rst), .req_valid_i(vld), .req_i(req), .req_ready_o(rdy),
    .done_o(done), .rdata_o(rdata), .bus_drive_keep_i(keep),
    .system_pullup_disable_reg_i(spud), .port_d_pullup_enable_reg_i(pur),
    .port_d_gpio_en_i(gen), .port_d_dir_i(dir), .port_d_out_i(pout), .port_d_in_o(pin),
    .addr_o(addr), .addr_oe_o(aoe), .data_o(dout), .data_oe_o(doe), .data_i(din),
    .store_strobe_n_o(st_n), .fetch_strobe_n_o(fe_n), .ctrl_oe_o(coe),
    .store_pullup_o(st_pu), .program_select_n_o(ps_n), .program_select_oe_o(ps_oe),
    .program_select_n_i(ps_pin), .program_select_pullup_o(ps_pu),
    .data_select_n_o(ds_n), .data_select_oe_o(ds_oe), .data_select_n_i(ds_pin),
    .data_select_pullup_o(ds_pu));
  ebs_sram_model u_prog (.addr_i(addr), .data_i(dout), .data_oe_i(doe), .store_n_i(st_n),
    .fetch_n_i(fe_n), .select_n_i(ps_pin), .data_o(p_rd));
  ebs_sram_model u_data (.addr_i(addr), .data_i(dout), .data_oe_i(doe), .store_n_i(st_n),
    .fetch_n_i(fe_n), .select_n_i(ds_pin), .data_o(d_rd));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input string what, input logic [23:0] e, input logic [23:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic access(input logic wr, input logic sp, input logic [23:0] a,
                        input logic [15:0] d);
    int s, f, k;
    s = 0;
    f = 0;
    // only raise the request once the unit shows idle
    for (k = 0; k < 20 && rdy !== 1'b1; k++) @(negedge clk);
    if (rdy !== 1'b1) begin
      n_errors++;
      test_done();
    end
    req = '{write: wr, space: sp, addr: a, wdata: d};
    vld = 1'b1;
    @(negedge clk);
    vld = 1'b0;
    for (k = 0; k < 20 && done !== 1'b1; k++) begin
      chk("strobe overlap", 24'h1, 24'(st_n | fe_n));
      if (!st_n) begin
        s++;
        chk("write data", {7'h0, 1'b1, d}, {7'h0, doe, dout});
        chk("address", 24'(a[16:0]), 24'(addr[16:0]));
      end
      if (!fe_n) f++;
      if (!fe_n) chk("read data oe", 24'h0, 24'(doe));
      if (!(st_n & fe_n)) chk("selects", 24'({sp, !sp}), 24'({ps_n, ds_n}));
      @(negedge clk);
    end
    if (done !== 1'b1) begin
      n_errors++;
      test_done();
    end
    chk("store cycles", 24'(wr ? SL : 0), 24'(s));
    chk("fetch cycles", 24'(wr ? 0 : SL), 24'(f));
    chk("idle pins", 24'hf, 24'({st_n, fe_n, ps_n, ds_n}));
    chk("idle drive", 24'({keep, keep}), 24'({aoe, coe}));
    if (!wr) chk("read word", 24'(sp ? exp_d[a[7:0]] : exp_p[a[7:0]]), 24'(rdata));
    if (wr && sp) exp_d[a[7:0]] = d;
    if (wr && !sp) exp_p[a[7:0]] = d;
  endtask
  initial begin
    int i;
    logic sp;
    logic [23:0] a;
    logic [15:0] d;
    rst = 1'b1;
    vld = 1'b0;
    keep = 1'b1;
    spud = 1'b0;
    ext = 1'b0;
    pur = 16'hffff;
    gen = 2'b00;
    dir = 2'b00;
    pout = 2'b00;
    req = '0;
    void'($urandom(80016));
    repeat (20) @(negedge clk);
    chk("reset pins", 24'h07f, 24'({aoe, doe, coe, ps_oe, ds_oe, st_n, fe_n, ps_n, ds_n,
        st_pu, ps_pu, ds_pu}));
    rst = 1'b0;
    for (i = 0; i < 24; i++) begin
      keep = i[0];
      sp = 1'($urandom);
      a = (i == 0) ? 24'hffffff : 24'($urandom);
      d = (i == 1) ? 16'h0000 : 16'($urandom);
      access(1'b1, sp, a, d);
      access(1'b0, sp, a, d);
    end
    $display("test random_access done");
    spud = 1'b1;
    pur = 16'hfcff;
    repeat (2) @(negedge clk);
    chk("pullups off", 24'h0, 24'({st_pu, ps_pu, ds_pu}));
    spud = 1'b0;
    pur = 16'h0100;
    repeat (2) @(negedge clk);
    chk("pullups bit8", 24'h6, 24'({st_pu, ps_pu, ds_pu}));
    $display("test pullups done");
    gen = 2'b11;
    dir = 2'b11;
    for (i = 0; i < 4; i++) begin
      pout = 2'(i);
      repeat (3) @(negedge clk);
      chk("gpio out", 24'({2'b11, 2'(i), 2'(i)}),
          24'({ds_oe, ps_oe, ds_n, ps_n, pin}));
    end
    dir = 2'b00;
    pur = 16'h0000;
    for (i = 0; i < 4; i++) begin
      ext = 1'($urandom);
      repeat (3) @(negedge clk);
      chk("gpio in", 24'({ext, ext}), 24'(pin));
    end
    $display("test gpio done");
    test_done();
  end
endmodule
